// [hw/tsr_pkg.sv]
// package for the temperature sensor init and result core
// Operation
// R01: init period ignores bus; host waits
// R02: after init, idle until bus reset
// R03: restore short address, thresholds, offset
// R04: restore io configuration from storage
// R05: restore both configuration registers
// R06: arbitration field 10b/11b selects arbitration search
// R07: fast speed unless first reset standard (code also needs the config2 fast bit set)
// R08: restore protection bits, apply write protect
// R09: on supply loss keep settings, continue
// R10: brown-out turns off; next start bus-powered
// R11: host keeps line idle during conversions
// R12: convert on command, after presence, continuous
// R13: conversion end updates result and status
// R14: encoding select bit, legacy after restore (code loads the bit from nvImage.config1)
// R15: precision: 16-bit two's complement result
// R16: legacy: 12-bit, sign-extended five bits
// R17: result reads zero before first conversion
// R18: legacy overrange saturates, no wrap
// R19: add stored offset before storing result
package tsr_pkg;
    // register byte addresses
    localparam logic [7:0] REG_RESULT_LO = 8'h00;
    localparam logic [7:0] REG_RESULT_HI = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_CONFIG1 = 8'h10;
    localparam logic [7:0] REG_CONFIG2 = 8'h14;
    localparam logic [7:0] REG_OFFSET = 8'h18;
    localparam logic [7:0] REG_ALERT_LO = 8'h1C;
    localparam logic [7:0] REG_ALERT_HI = 8'h20;
    localparam logic [7:0] REG_SHORT_ADDR = 8'h24;
    localparam logic [7:0] REG_IO_CONFIG = 8'h28;
    localparam logic [7:0] REG_PROTECT = 8'h2C;
    localparam logic [7:0] REG_CONTROL = 8'h30;
    localparam logic [7:0] REG_DEVICE_ID = 8'h34;
    // field positions
    localparam int CFG1_FMT_BIT = 0;
    localparam int CFG1_AUTO_BIT = 1;
    localparam int CFG2_ARB_LSB = 0;
    localparam int CFG2_FAST_BIT = 2;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_INIT_BIT = 1;
    localparam int ST_BROWN_BIT = 2;
    localparam int ST_RESET_BIT = 3;
    localparam int CTL_CONVERT_BIT = 0;
    // reset value, legacy limits and device id
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] LEGACY_MAX = 16'h07FF;
    localparam logic [15:0] LEGACY_MIN = 16'hF800;
    localparam logic [31:0] DEVICE_ID_VALUE = 32'h0000_00A5; // arbitrary value
    // timing and storage word count
    localparam int CLK_HZ = 50_000_000;
    localparam int INIT_TIME_US = 1000;
    localparam int INIT_CYCLES = (INIT_TIME_US * (CLK_HZ / 1_000_000));
    localparam int CONV_TIME_US = 5500;
    localparam int CONV_CYCLES = (CONV_TIME_US * (CLK_HZ / 1_000_000));
    localparam int NV_WORDS = 9;

    typedef enum {ST_POWER_OFF, ST_RESTORE, ST_INIT_WAIT, ST_WAIT_RESET, ST_ACTIVE} tsr_state_t;

    typedef struct packed {
        logic [7:0] shortAddr;
        logic [15:0] alertLo;
        logic [15:0] alertHi;
        logic [15:0] offset;
        logic [7:0] ioConfig;
        logic [7:0] config1;
        logic [7:0] config2;
        logic [7:0] protect;
    } tsr_nv_image_t;

    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } tsr_sample_t;
endpackage

// [hw/tsr_core.sv]
// temperature sensor init, power mode and result core
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
module tsr_core import tsr_pkg::*; #(
    parameter int INIT_CYC = INIT_CYCLES,
    parameter int CONV_CYC = CONV_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // avalon-mm slave
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // power and storage
    input wire logic supplyGood,
    input wire logic vddPresent,
    input wire logic brownOut,
    input wire tsr_nv_image_t nvImage,
    // link events from bit engine
    input wire logic busResetSeen,
    input wire logic busResetStandard,
    input wire logic presenceDone,
    input wire logic convertCommand,
    // converter
    input wire tsr_sample_t rawSample,
    output logic convStart,
    // status to link logic
    output logic linkEnable,
    output logic fastSpeed,
    output logic searchArbitration,
    output logic busPowered,
    output logic [7:0] writeProtect,
    output logic [7:0] shortAddress,
    output logic [7:0] ioConfig,
    output logic shutdown,
    output logic irq
);
    if (INIT_CYC < 1 || CONV_CYC < 1) begin : g_badCycles
        $error("cycle counts must be positive");
    end

    logic rstS1, rstS2, rst;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstS1 <= 1'b0;
            rstS2 <= 1'b0;
        end else begin
            rstS1 <= 1'b1;
            rstS2 <= rstS1;
        end
    end
    assign rst = ~rstS2;

    tsr_state_t state_q;
    logic [31:0] initCnt_q;
    logic [31:0] convCnt_q;
    logic converting_q;
    logic firstReset_q;
    logic busModeNext_q;
    logic [7:0] cfg1_q, cfg2_q, prot_q, ioCfg_q, shortAddr_q;
    logic [15:0] offset_q, alertLo_q, alertHi_q, result_q;
    logic [3:0] status_q, mask_q;
    logic [31:0] rdata_q;
    logic wait_q;

    wire busWr = avsWrite & wait_q;
    wire running = (state_q == ST_ACTIVE);
    wire lowByteWr = busWr & avsByteEnable[0];
    wire [1:0] arbField = cfg2_q[CFG2_ARB_LSB +: 2];

    // power state machine
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_POWER_OFF;
            initCnt_q <= '0;
        end else begin
            case (state_q)
                ST_POWER_OFF: begin
                    if (supplyGood && !brownOut) begin
                        state_q <= ST_RESTORE;
                    end
                end
                ST_RESTORE: begin
                    state_q <= ST_INIT_WAIT;
                    initCnt_q <= '0;
                end
                ST_INIT_WAIT: begin
                    initCnt_q <= initCnt_q + 32'h0000_0001;
                    if (initCnt_q >= INIT_CYC - 1) begin // R01
                        state_q <= ST_WAIT_RESET;
                    end
                end
                ST_WAIT_RESET: begin
                    if (busResetSeen) begin // R02
                        state_q <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    state_q <= ST_ACTIVE;
                end
                default: begin
                    state_q <= ST_POWER_OFF;
                end
            endcase
            if (brownOut && state_q != ST_POWER_OFF) begin // R10
                state_q <= ST_POWER_OFF;
            end
        end
    end

    // bus powered on next start after brown-out; loss of supply keeps settings
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busModeNext_q <= 1'b0;
        end else if (brownOut) begin
            busModeNext_q <= 1'b1; // R10
        end else if (state_q == ST_RESTORE) begin
            busModeNext_q <= busModeNext_q | ~vddPresent; // R10
        end else if (running) begin
            busModeNext_q <= ~vddPresent; // R09
        end
    end

    // fast speed from the stored config2 speed bit, cleared if the first reset came at standard speed
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            firstReset_q <= 1'b1;
            fastSpeed <= 1'b0;
        end else if (state_q == ST_RESTORE) begin
            firstReset_q <= 1'b1;
            fastSpeed <= nvImage.config2[CFG2_FAST_BIT];
        end else if (busResetSeen && firstReset_q && state_q == ST_WAIT_RESET) begin
            firstReset_q <= 1'b0;
            fastSpeed <= cfg2_q[CFG2_FAST_BIT] & ~busResetStandard; // R07
        end
    end

    // configuration registers: restore or software write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shortAddr_q <= '0;
            alertLo_q <= '0;
            alertHi_q <= '0;
            offset_q <= '0;
            ioCfg_q <= '0;
            cfg1_q <= '0;
            cfg2_q <= '0;
            prot_q <= '0;
            mask_q <= '0;
        end else if (state_q == ST_RESTORE) begin
            shortAddr_q <= nvImage.shortAddr; // R03
            alertLo_q <= nvImage.alertLo; // R03
            alertHi_q <= nvImage.alertHi; // R03
            offset_q <= nvImage.offset; // R03
            ioCfg_q <= nvImage.ioConfig; // R04
            cfg1_q <= nvImage.config1; // R05
            cfg2_q <= nvImage.config2; // R05
            prot_q <= nvImage.protect; // R08
        end else if (lowByteWr) begin
            case (avsAddress)
                REG_CONFIG1: cfg1_q <= avsWriteData[7:0];
                REG_CONFIG2: cfg2_q <= avsWriteData[7:0];
                REG_OFFSET: offset_q <= avsWriteData[15:0];
                REG_ALERT_LO: alertLo_q <= avsWriteData[15:0];
                REG_ALERT_HI: alertHi_q <= avsWriteData[15:0];
                REG_SHORT_ADDR: shortAddr_q <= avsWriteData[7:0];
                REG_IO_CONFIG: ioCfg_q <= avsWriteData[7:0];
                REG_PROTECT: prot_q <= avsWriteData[7:0];
                REG_IRQ_MASK: mask_q <= avsWriteData[3:0];
                default: ;
            endcase
        end
    end

    // conversion start and timer
    wire swConvert = lowByteWr && avsAddress == REG_CONTROL && avsWriteData[CTL_CONVERT_BIT];
    wire autoConv = cfg1_q[CFG1_AUTO_BIT];
    wire startReq = running && !converting_q &&
        ((!autoConv && (convertCommand || swConvert)) || (autoConv && presenceDone) || vddPresent); // R12
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            converting_q <= 1'b0;
            convCnt_q <= '0;
            convStart <= 1'b0;
        end else begin
            convStart <= startReq;
            if (!running) begin
                converting_q <= 1'b0;
            end else if (startReq) begin
                converting_q <= 1'b1;
                convCnt_q <= '0;
            end else if (converting_q && rawSample.valid) begin
                converting_q <= 1'b0;
            end else if (converting_q) begin
                convCnt_q <= convCnt_q + 32'h0000_0001;
            end
        end
    end

    // result formatting with offset
    logic [16:0] sum;
    logic [15:0] formatted;
    always_comb begin
        sum = {rawSample.value[15], rawSample.value} + {offset_q[15], offset_q}; // R19
        if (sum[16] != sum[15]) begin
            formatted = sum[16] ? 16'h8000 : 16'h7FFF;
        end else begin
            formatted = sum[15:0]; // R15
        end
        if (!cfg1_q[CFG1_FMT_BIT]) begin // R14
            if ($signed(formatted) > $signed({LEGACY_MAX[12:0], 3'h7})) begin
                formatted = LEGACY_MAX; // R18
            end else if ($signed(formatted) < $signed({LEGACY_MIN[12:0], 3'h0})) begin
                formatted = LEGACY_MIN;
            end else begin
                formatted = {{5{formatted[15]}}, formatted[13:3]}; // R16
            end
        end
    end

    wire convDone = converting_q && rawSample.valid && running;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            result_q <= RESULT_RESET; // R17
        end else if (state_q == ST_RESTORE) begin
            result_q <= RESULT_RESET; // R17
        end else if (convDone) begin
            result_q <= formatted; // R13
        end
    end

    // sticky status, write one to clear, set wins
    logic [3:0] evt;
    assign evt = {busResetSeen & running, state_q == ST_INIT_WAIT && initCnt_q >= INIT_CYC - 1,
        brownOut, convDone};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~((lowByteWr && avsAddress == REG_STATUS) ? avsWriteData[3:0] : 4'h0))
                | evt; // R13
        end
    end

    // avalon slave: one wait cycle, then answer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b0;
            avsWaitRequest <= 1'b1;
            rdata_q <= '0;
        end else begin
            wait_q <= (avsRead | avsWrite) & ~wait_q;
            avsWaitRequest <= ~((avsRead | avsWrite) & ~wait_q);
            if ((avsRead | avsWrite) & ~wait_q) begin
                case (avsAddress)
                    REG_RESULT_LO: rdata_q <= {24'h0, result_q[7:0]};
                    REG_RESULT_HI: rdata_q <= {24'h0, result_q[15:8]};
                    REG_STATUS: rdata_q <= {28'h0, status_q};
                    REG_IRQ_MASK: rdata_q <= {28'h0, mask_q};
                    REG_CONFIG1: rdata_q <= {24'h0, cfg1_q};
                    REG_CONFIG2: rdata_q <= {24'h0, cfg2_q};
                    REG_OFFSET: rdata_q <= {16'h0, offset_q};
                    REG_ALERT_LO: rdata_q <= {16'h0, alertLo_q};
                    REG_ALERT_HI: rdata_q <= {16'h0, alertHi_q};
                    REG_SHORT_ADDR: rdata_q <= {24'h0, shortAddr_q};
                    REG_IO_CONFIG: rdata_q <= {24'h0, ioCfg_q};
                    REG_PROTECT: rdata_q <= {24'h0, prot_q};
                    REG_CONTROL: rdata_q <= {30'h0, converting_q, running};
                    REG_DEVICE_ID: rdata_q <= DEVICE_ID_VALUE;
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign avsReadData = rdata_q;

    // registered outputs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            linkEnable <= 1'b0;
            searchArbitration <= 1'b0;
            busPowered <= 1'b0;
            writeProtect <= '0;
            shortAddress <= '0;
            ioConfig <= '0;
            shutdown <= 1'b1;
            irq <= 1'b0;
        end else begin
            linkEnable <= (state_q == ST_WAIT_RESET) || running; // R01
            searchArbitration <= arbField[1]; // R06
            busPowered <= busModeNext_q; // R10
            writeProtect <= prot_q; // R08
            shortAddress <= shortAddr_q;
            ioConfig <= ioCfg_q;
            shutdown <= (state_q == ST_POWER_OFF);
            irq <= |(status_q & mask_q);
        end
    end
endmodule

// [bench/tsr_core_checker.sv]
// assertion checker for the sensor core ports
`timescale 1ns/10ps
module tsr_core_checker import tsr_pkg::*; #(
    parameter int INIT_CYC = INIT_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // register bus
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic [31:0] avsReadData,
    input wire logic avsWaitRequest,
    // power and events
    input wire logic supplyGood,
    input wire logic vddPresent,
    input wire logic brownOut,
    input wire tsr_nv_image_t nvImage,
    input wire logic busResetSeen,
    input wire logic busResetStandard,
    input wire tsr_sample_t rawSample,
    // status
    input wire logic linkEnable,
    input wire logic fastSpeed,
    input wire logic searchArbitration,
    input wire logic busPowered,
    input wire logic [7:0] writeProtect,
    input wire logic [7:0] shortAddress,
    input wire logic [7:0] ioConfig,
    input wire logic shutdown
);
    int initCnt_q;
    logic seen_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // cycles with supply in range, and first sample seen
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) initCnt_q <= 0;
        else if (!supplyGood) initCnt_q <= 0;
        else if (initCnt_q < INIT_CYC) initCnt_q <= initCnt_q + 1;
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) seen_q <= 1'b0;
        else if (rawSample.valid) seen_q <= 1'b1;
    end
    property p_init; initCnt_q < INIT_CYC |-> !linkEnable; endproperty
    property p_addr; $rose(linkEnable) |-> shortAddress == nvImage.shortAddr; endproperty
    property p_prot; $rose(linkEnable) |-> ioConfig == nvImage.ioConfig && writeProtect == nvImage.protect; endproperty
    property p_arb; $rose(linkEnable) |-> searchArbitration == nvImage.config2[1]; endproperty
    property p_fast; $rose(linkEnable) |-> fastSpeed == nvImage.config2[CFG2_FAST_BIT]; endproperty
    property p_slow; busResetSeen && busResetStandard && linkEnable |-> ##[1:3] !fastSpeed; endproperty
    property p_keep;
        $fell(vddPresent) && !brownOut |=>
            $stable(shortAddress) && $stable(ioConfig) && $stable(writeProtect) && !shutdown;
    endproperty
    property p_bus; $fell(vddPresent) && !brownOut |-> ##[1:3] busPowered; endproperty
    property p_off; $rose(brownOut) |-> ##[1:3] shutdown; endproperty
    property p_offLink; shutdown [*2] |-> !linkEnable; endproperty
    property p_zero;
        avsRead && !avsWaitRequest && !seen_q && (avsAddress == REG_RESULT_LO || avsAddress == REG_RESULT_HI)
        |-> avsReadData == 32'h0000_0000;
    endproperty
    a_init: assert property (p_init) else $error("link enabled during init");
    a_addr: assert property (p_addr) else $error("short address not restored");
    a_prot: assert property (p_prot) else $error("io or protection not restored");
    a_arb: assert property (p_arb) else $error("arbitration mode not restored");
    a_fast: assert property (p_fast) else $error("fast speed not restored");
    a_slow: assert property (p_slow) else $error("standard reset kept fast speed");
    a_keep: assert property (p_keep) else $error("settings lost on supply loss");
    a_bus: assert property (p_bus) else $error("bus powered mode not entered");
    a_off: assert property (p_off) else $error("no shutdown on brown-out");
    a_offLink: assert property (p_offLink) else $error("link active while shut down");
    a_zero: assert property (p_zero) else $error("result not zero before first conversion");
    c_link: cover property ($rose(linkEnable));
    c_brown: cover property ($rose(shutdown));
    c_sample: cover property (rawSample.valid);
endmodule

bind tsr_core tsr_core_checker #(.INIT_CYC(INIT_CYC)) u_chk (.*);

// [bench/tsr_host_model.sv]
// host link and converter model facing the sensor core
`timescale 1ns/10ps
module tsr_host_model import tsr_pkg::*; (
    // clock
    input wire logic ref_clk,
    // converter handshake
    input wire logic convStart,
    output tsr_sample_t rawSample,
    // link events
    output logic busResetSeen,
    output logic busResetStandard,
    output logic presenceDone,
    output logic convertCommand
);
    int convDelay = 4;
    int cnt = 0;
    logic [15:0] tempVal = 16'h0000;
    initial begin
        rawSample = '0;
        {busResetSeen, busResetStandard, presenceDone, convertCommand} = 4'h0;
    end
    // sample ends conversion; idle value toggles so it never looks valid
    always @(posedge ref_clk) begin
        if (cnt == 1) rawSample <= {1'b1, tempVal};
        else rawSample <= {1'b0, ~rawSample.value};
        if (convStart) cnt <= convDelay;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    // which: 0 bus reset, 1 presence, 2 convert command
    task automatic pulse(input int which, input logic std);
        int n;
        n = 0;
        @(posedge ref_clk);
        while (cnt != 0 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        busResetSeen <= (which == 0);
        busResetStandard <= std;
        presenceDone <= (which == 1);
        convertCommand <= (which == 2);
        @(posedge ref_clk);
        {busResetSeen, busResetStandard, presenceDone, convertCommand} <= 4'h0;
        @(negedge ref_clk);
    endtask
endmodule

// [bench/testbench.sv]
// self-checking bench for the sensor core
`timescale 1ns/10ps
module testbench import tsr_pkg::*; ;
    logic ref_clk = 1'b0, arst_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
    logic [7:0] avsAddress = 8'h00;
    logic [31:0] avsWriteData = 32'h0000_0000;
    logic [3:0] avsByteEnable = 4'hF;
    logic supplyGood = 1'b1, vddPresent = 1'b0, brownOut = 1'b0;
    tsr_nv_image_t nvImage = {8'h5A, 16'hF380, 16'h3200, 16'h0000, 8'h3C, 8'h00, 8'h06, 8'hC3};
    logic [31:0] avsReadData, q;
    logic avsWaitRequest, busResetSeen, busResetStandard, presenceDone, convertCommand, convStart;
    logic linkEnable, fastSpeed, searchArbitration, busPowered, shutdown, irq;
    logic [7:0] writeProtect, shortAddress, ioConfig;
    tsr_sample_t rawSample;
    int nFail = 0, checkCount = 0;
    logic [15:0] rawTab [4] = '{16'h0C80, 16'hFF80, 16'h3F80, 16'hFC00};
    logic [15:0] legTab [4] = '{16'h0190, 16'hFFF0, 16'h07F0, 16'hFF80};
    tsr_core #(.INIT_CYC(10), .CONV_CYC(10)) u_dut (.*);
    tsr_host_model u_host (.*);
    initial forever #10 ref_clk = ~ref_clk;
    task automatic closeOut;
        $display("checks %0d fails %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checkCount++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    // one bus access: held until waitrequest is sampled low at a rising edge
    task automatic avs(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 40);
        q = avsReadData;
        if (avsWaitRequest !== 1'b0) begin
            nFail++;
            $display("[FAIL] %0t bus access timed out", $time);
        end
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        avs(1'b0, a, 32'h0000_0000);
        chk(q[15:0], e);
    endtask
    task automatic rdres(input logic [15:0] e);
        logic [7:0] lo;
        avs(1'b0, REG_RESULT_LO, 32'h0000_0000);
        lo = q[7:0];
        avs(1'b0, REG_RESULT_HI, 32'h0000_0000);
        chk({q[7:0], lo}, e);
    endtask
    task automatic conv(input logic [15:0] raw, input int how);
        int i;
        u_host.tempVal = raw;
        avs(1'b1, REG_STATUS, 32'h0000_000F);
        // how: 0 to 2 host pulse, 3 control register write
        if (how < 3) u_host.pulse(how, 1'b0);
        else avs(1'b1, REG_CONTROL, 32'h0000_0001);
        i = 0;
        do begin
            avs(1'b0, REG_STATUS, 32'h0000_0000);
            i++;
        end while (q[ST_DONE_BIT] !== 1'b1 && i < 30);
        chk({15'h0000, q[ST_DONE_BIT]}, 16'h0001);
    endtask
    task automatic waitLink;
        for (int i = 0; i < 200 && linkEnable !== 1'b1; i++) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({15'h0000, linkEnable}, 16'h0001);
    endtask
    initial begin
        #1_000_000;
        nFail++;
        $display("[FAIL] %0t watchdog expired", $time);
        closeOut();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        waitLink();
        rdres(16'h0000);
        rdchk(REG_SHORT_ADDR, 16'h005A);
        rdchk(REG_ALERT_LO, 16'hF380);
        rdchk(REG_ALERT_HI, 16'h3200);
        rdchk(REG_OFFSET, 16'h0000);
        rdchk(REG_IO_CONFIG, 16'h003C);
        rdchk(REG_CONFIG1, 16'h0000);
        rdchk(REG_CONFIG2, 16'h0006);
        rdchk(REG_PROTECT, 16'h00C3);
        chk({8'h00, writeProtect}, 16'h00C3);
        chk({shortAddress, ioConfig}, 16'h5A3C);
        chk({15'h0000, searchArbitration}, 16'h0001);
        chk({15'h0000, fastSpeed}, 16'h0001);
        rdchk(REG_DEVICE_ID, DEVICE_ID_VALUE[15:0]);
        rdchk(8'h3C, 16'h0000);
        @(posedge ref_clk) avsByteEnable <= 4'hE;
        avs(1'b1, REG_SHORT_ADDR, 32'h0000_0011);
        @(posedge ref_clk) avsByteEnable <= 4'hF;
        rdchk(REG_SHORT_ADDR, 16'h005A);
        avs(1'b1, REG_RESULT_LO, 32'h0000_00FF);
        rdres(16'h0000);
        u_host.tempVal = 16'h0C80;
        u_host.pulse(2, 1'b0);
        idle(20);
        rdres(16'h0000);
        u_host.pulse(0, 1'b1);
        idle(3);
        chk({15'h0000, fastSpeed}, 16'h0000);
        avs(1'b1, REG_IRQ_MASK, 32'h0000_0001);
        conv(16'h4B00, 2);
        rdres(16'h07FF);
        chk({15'h0000, irq}, 16'h0001);
        avs(1'b1, REG_IRQ_MASK, 32'h0000_0000);
        idle(1);
        chk({15'h0000, irq}, 16'h0000);
        avs(1'b1, REG_IRQ_MASK, 32'h0000_0001);
        idle(1);
        chk({15'h0000, irq}, 16'h0001);
        avs(1'b1, REG_STATUS, 32'h0000_000F);
        idle(1);
        chk({15'h0000, irq}, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            conv(rawTab[k], 2);
            rdres(legTab[k]);
        end
        avs(1'b1, REG_CONFIG1, 32'h0000_0001);
        avs(1'b1, REG_OFFSET, 32'h0000_0080);
        u_host.convDelay = 20;
        conv(16'h0C80, 2);
        rdres(16'h0D00);
        conv(16'hFC00, 3);
        rdres(16'hFC80);
        avs(1'b1, REG_CONFIG1, 32'h0000_0003);
        conv(16'h0100, 1);
        rdres(16'h0180);
        avs(1'b1, REG_STATUS, 32'h0000_000F);
        u_host.tempVal = 16'h3200;
        @(posedge ref_clk) vddPresent <= 1'b1;
        idle(60);
        rdchk(REG_STATUS, 16'h0001);
        rdres(16'h3280);
        @(posedge ref_clk) vddPresent <= 1'b0;
        idle(5);
        chk({14'h0000, busPowered, shutdown}, 16'h0002);
        rdchk(REG_SHORT_ADDR, 16'h005A);
        @(posedge ref_clk) brownOut <= 1'b1;
        idle(5);
        chk({14'h0000, shutdown, linkEnable}, 16'h0002);
        @(posedge ref_clk) brownOut <= 1'b0;
        supplyGood <= 1'b0;
        idle(3);
        @(posedge ref_clk) supplyGood <= 1'b1;
        vddPresent <= 1'b1;
        waitLink();
        chk({15'h0000, busPowered}, 16'h0001);
        closeOut();
    end
endmodule
